// [hdl/cmp_change_detect.sv]
// Synchroniser, output hold and mismatch detector for the comparators
`timescale 1ns/100ps
module cmp_change_detect #(
  parameter int unsigned N = 2
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Comparator side
  input wire logic [N-1:0] raw_in,
  input wire logic hold_in,
  input wire logic relatch_in,
  // Results
  output logic [N-1:0] live_out,
  output logic mismatch_out
);

  if (N < 1) begin : g_bad_width
    $error("cmp_change_detect needs at least one comparator");
  end

  logic [N-1:0] sync1_q;
  logic [N-1:0] sync2_q;
  logic [N-1:0] live_q;
  logic [N-1:0] live_d;
  logic [N-1:0] ref_q;
  logic [N-1:0] ref_d;

  for (genvar i = 0; i < N; i++) begin : g_sync
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= raw_in[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  always_comb begin
    // Frozen while powered down so the analog settling cannot flag
    live_d = hold_in ? live_q : sync2_q;
    // Relatch takes the value being presented this cycle
    ref_d = relatch_in ? live_q : ref_q;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      live_q <= '0;
      ref_q <= '0;
    end else begin
      live_q <= live_d;
      ref_q <= ref_d;
    end
  end

  assign live_out = live_q;
  assign mismatch_out = |(live_q ^ ref_q);

endmodule

// [hdl/cmp_change_irq.sv]
// Comparator change interrupt block with its AHB-Lite register slave
`timescale 1ns/100ps
module cmp_change_irq
  import cmp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,

  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [DATA_W-1:0] hwdata_in,
  output logic [DATA_W-1:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,

  // Comparator outputs from the analog side
  input wire logic cmp_one_raw_in,
  input wire logic cmp_two_raw_in,

  // Device power state
  input wire logic sleep_in,

  // Analog control
  output logic cmp_power_down_out,
  output logic [MODE_W-1:0] cmp_mode_out,

  // Interrupt and wake
  output logic cmp_irq_out,
  output logic wake_out,
  output logic irq_out
);

  // Bus front end state
  bus_state_t state_q;
  bus_state_t state_d;
  logic [OFS_W-1:0] addr_q;
  logic [OFS_W-1:0] addr_d;
  logic ok_q;
  logic ok_d;
  logic ready_q;
  logic ready_d;
  logic [DATA_W-1:0] hrdata_q;
  logic [DATA_W-1:0] hrdata_d;
  logic resp_q;
  logic resp_d;

  // Register state
  logic [MODE_W-1:0] mode_q;
  logic [MODE_W-1:0] mode_d;
  logic flag_q;
  logic flag_d;
  logic change_en_q;
  logic change_en_d;
  logic periph_en_q;
  logic periph_en_d;
  logic global_en_q;
  logic global_en_d;
  logic cmp_irq_q;
  logic cmp_irq_d;
  logic wake_q;
  logic wake_d;
  logic power_down_q;
  logic power_down_d;

  // Decoded strobes and read mux
  logic accept;
  logic wr_en;
  logic rd_en;
  logic wr_ctrl;
  logic wr_flag;
  logic wr_enable;
  logic wr_irq_ctl;
  logic ctrl_access;
  logic [DATA_W-1:0] read_value;

  // Comparator side
  logic [NUM_CMP-1:0] cmp_live;
  logic mismatch;
  logic cmp_one_output;
  logic cmp_two_output;

  irq_evt_if evt ();

  if (NUM_CMP != 2) begin : g_bad_count
    $error("cmp_change_irq serves exactly two comparators");
  end

  // Each register is one aligned word, so every field must fit in it
  if (DATA_W != 32) begin : g_bad_data
    $error("cmp_change_irq needs a 32-bit data bus");
  end

  // The offset field must hold the whole map and leave the upper
  // address bits for the decode that ignores other addresses
  if ((OFS_W < 5) || (OFS_W > 31)) begin : g_bad_offset
    $error("cmp_change_irq offset width out of range");
  end

  if ((CTRL_CMP_TWO_BIT >= DATA_W) ||
      (CTRL_CMP_ONE_BIT >= DATA_W)) begin : g_bad_ctrl
    $error("cmp_change_irq output bits lie outside the word");
  end

  // Mode encodings are three bits wide and sit below the output bits
  if ((MODE_W != 3) ||
      (MODE_LSB + MODE_W > CTRL_CMP_ONE_BIT)) begin : g_bad_mode
    $error("cmp_change_irq mode field does not fit");
  end

  if ((FLAG_BIT >= DATA_W) || (CHANGE_EN_BIT >= DATA_W) ||
      (GLOBAL_EN_BIT >= DATA_W) || (PERIPH_EN_BIT >= DATA_W) ||
      (GLOBAL_EN_BIT == PERIPH_EN_BIT)) begin : g_bad_enable
    $error("cmp_change_irq flag or enable bit out of place");
  end

  // Two sticky events: the hardware change and the software set
  if ((EVT_W != 2) || (EVT_CHANGE == EVT_SOFT)) begin : g_bad_event
    $error("cmp_change_irq needs two distinct sticky events");
  end

  cmp_change_detect #(
    .N(NUM_CMP)
  ) u_detect (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .raw_in({cmp_two_raw_in, cmp_one_raw_in}),
    .hold_in(power_down_q),
    .relatch_in(ctrl_access),
    .live_out(cmp_live),
    .mismatch_out(mismatch)
  );

  irq_sticky_unit u_irq (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .evt(evt)
  );

  assign cmp_one_output = cmp_live[0];
  assign cmp_two_output = cmp_live[1];

  // Bus handshake. Reads take one wait state so that a write just
  // before them is already stored when the read data is captured.
  assign accept = hsel_in & htrans_in[1] & ready_q;
  assign wr_en = (state_q == BUS_WRITE) & ok_q;
  assign rd_en = (state_q == BUS_READ) & ok_q;

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    ok_d = ok_q;
    ready_d = ready_q;
    hrdata_d = hrdata_q;
    // Transfers other than aligned whole words are ignored rather than refused, so every answer is OKAY
    resp_d = HRESP_OKAY;
    unique case (state_q)
      BUS_IDLE, BUS_WRITE: begin
        if (accept) begin
          addr_d = haddr_in[OFS_W-1:0];
          ok_d = (haddr_in[31:OFS_W] == '0) &
                 (haddr_in[1:0] == 2'h0) & (hsize_in == HSIZE_WORD);
          state_d = hwrite_in ? BUS_WRITE : BUS_READ;
          ready_d = hwrite_in;
        end else begin
          state_d = BUS_IDLE;
          ready_d = 1'b1;
        end
      end
      BUS_READ: begin
        hrdata_d = ok_q ? read_value : RDATA_RESET;
        ready_d = 1'b1;
        state_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= BUS_IDLE;
      addr_q <= OFS_CMP_CONTROL;
      ok_q <= 1'b0;
      ready_q <= 1'b1;
      hrdata_q <= RDATA_RESET;
      resp_q <= HRESP_OKAY;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      ok_q <= ok_d;
      ready_q <= ready_d;
      hrdata_q <= hrdata_d;
      resp_q <= resp_d;
    end
  end

  // Register decode
  assign wr_ctrl = wr_en & (addr_q == OFS_CMP_CONTROL);
  assign wr_flag = wr_en & (addr_q == OFS_PERIPH_FLAG);
  assign wr_enable = wr_en & (addr_q == OFS_PERIPH_ENABLE);
  assign wr_irq_ctl = wr_en & (addr_q == OFS_IRQ_CONTROL);
  assign ctrl_access = (wr_en | rd_en) & (addr_q == OFS_CMP_CONTROL);

  always_comb begin
    read_value = RDATA_RESET;
    unique case (addr_q)
      OFS_CMP_CONTROL: begin
        read_value[CTRL_CMP_TWO_BIT] = cmp_two_output;
        read_value[CTRL_CMP_ONE_BIT] = cmp_one_output;
        read_value[MODE_LSB +: MODE_W] = mode_q;
      end
      OFS_PERIPH_FLAG: begin
        read_value[FLAG_BIT] = flag_q;
      end
      OFS_PERIPH_ENABLE: begin
        read_value[CHANGE_EN_BIT] = change_en_q;
      end
      OFS_IRQ_CONTROL: begin
        read_value[GLOBAL_EN_BIT] = global_en_q;
        read_value[PERIPH_EN_BIT] = periph_en_q;
      end
      OFS_IRQ_STATUS: begin
        read_value[EVT_W-1:0] = evt.status;
      end
      OFS_IRQ_MASK: begin
        read_value[EVT_W-1:0] = evt.mask;
      end
      default: begin
        read_value = RDATA_RESET;
      end
    endcase
  end

  // Control, flag and enable registers
  always_comb begin
    // Sleep has no path into the mode field, so waking keeps it
    mode_d = mode_q;
    if (wr_ctrl) begin
      mode_d = hwdata_in[MODE_LSB +: MODE_W];
    end
    flag_d = flag_q;
    if (wr_flag) begin
      flag_d = hwdata_in[FLAG_BIT];
    end
    // A live mismatch wins over a clear in the same cycle, and keeps
    // setting the flag until a control access relatches the outputs.
    // A change landing exactly on a relatch cycle is compared against
    // the new reference, which is the value before the change, and sets the flag.
    if (mismatch) begin
      flag_d = 1'b1;
    end
    change_en_d = wr_enable ? hwdata_in[CHANGE_EN_BIT] : change_en_q;
    periph_en_d = wr_irq_ctl ? hwdata_in[PERIPH_EN_BIT] : periph_en_q;
    global_en_d = wr_irq_ctl ? hwdata_in[GLOBAL_EN_BIT] : global_en_q;
    cmp_irq_d = flag_q & change_en_q & periph_en_q & global_en_q;
    // Wake does not need the global enable; the comparators keep
    // running in sleep, only the power-down modes stop them.
    wake_d = sleep_in & flag_q & change_en_q;
    power_down_d = (mode_d == MODE_OFF) | (mode_d == MODE_RESET);
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_q <= MODE_RESET;
      flag_q <= 1'b0;
      change_en_q <= 1'b0;
      periph_en_q <= 1'b0;
      global_en_q <= 1'b0;
      cmp_irq_q <= 1'b0;
      wake_q <= 1'b0;
      power_down_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      flag_q <= flag_d;
      change_en_q <= change_en_d;
      periph_en_q <= periph_en_d;
      global_en_q <= global_en_d;
      cmp_irq_q <= cmp_irq_d;
      wake_q <= wake_d;
      power_down_q <= power_down_d;
    end
  end

  // Sticky events: hardware change and software-forced flag
  always_comb begin
    evt.set = EVT_RESET;
    evt.set[EVT_CHANGE] = mismatch;
    evt.set[EVT_SOFT] = wr_flag & hwdata_in[FLAG_BIT];
    evt.wr_status = wr_en & (addr_q == OFS_IRQ_STATUS);
    evt.wr_mask = wr_en & (addr_q == OFS_IRQ_MASK);
    evt.wdata = hwdata_in[EVT_W-1:0];
  end

  // Outputs
  assign hrdata_out = hrdata_q;
  assign hreadyout_out = ready_q;
  assign hresp_out = resp_q;
  assign cmp_power_down_out = power_down_q;
  assign cmp_mode_out = mode_q;
  assign cmp_irq_out = cmp_irq_q;
  assign wake_out = wake_q;
  assign irq_out = evt.irq;

endmodule

// [hdl/irq_sticky_unit.sv]
// Sticky interrupt status with mask and one level interrupt
`timescale 1ns/100ps
module irq_sticky_unit
  import cmp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Carrier to the register top
  irq_evt_if.unit evt
);

  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] status_d;
  logic [EVT_W-1:0] mask_q;
  logic [EVT_W-1:0] mask_d;
  logic irq_q;
  logic irq_d;

  always_comb begin
    status_d = status_q;
    if (evt.wr_status) begin
      status_d = status_q & ~evt.wdata;
    end
    // A new event beats a simultaneous write-one clear
    status_d = status_d | evt.set;
    mask_d = evt.wr_mask ? evt.wdata : mask_q;
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_q <= EVT_RESET;
      mask_q <= EVT_RESET;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  assign evt.status = status_q;
  assign evt.mask = mask_q;
  assign evt.irq = irq_q;

endmodule

// [shared/cmp_pkg.sv]
// Constants, offsets and types of the comparator change interrupt block
// Notes on behaviour
// - Either comparator output differing from its previous value sets the change flag.
// - Change flag is bit 6 of the flag register; a written zero clears it.
// - Software writing one to the change flag sets it like a real change.
// - Comparator interrupt needs change, peripheral and global enables all set.
// - Change flag still sets while any of the three enables is clear.
// - A change coinciding with a control register read may fail to set the flag; this block still sets the flag in that case.
// - Any control register read or write relatches present comparator outputs.
// - Mismatch keeps setting the flag; software reads control before clearing.
// - Comparators keep working in sleep; enabled change interrupt wakes device.
// - Mode field all ones switches both comparators off.
// - Waking from sleep leaves the control register unchanged.
// - Reset forces control register to reset state, mode field all zeros.
// - Both comparators stay powered down throughout the reset interval.
// - Comparator outputs read back in control register bits 7 and 6.
package cmp_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned OFS_W = 8;
  localparam int unsigned NUM_CMP = 2;

  // Byte offsets on the register bus
  localparam logic [OFS_W-1:0] OFS_CMP_CONTROL = 8'h00;
  localparam logic [OFS_W-1:0] OFS_PERIPH_FLAG = 8'h04;
  localparam logic [OFS_W-1:0] OFS_PERIPH_ENABLE = 8'h08;
  localparam logic [OFS_W-1:0] OFS_IRQ_CONTROL = 8'h0C;
  localparam logic [OFS_W-1:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [OFS_W-1:0] OFS_IRQ_MASK = 8'h14;

  // Field positions
  localparam int unsigned CTRL_CMP_TWO_BIT = 7;
  localparam int unsigned CTRL_CMP_ONE_BIT = 6;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned FLAG_BIT = 6;
  localparam int unsigned CHANGE_EN_BIT = 6;
  localparam int unsigned GLOBAL_EN_BIT = 7;
  localparam int unsigned PERIPH_EN_BIT = 6;

  // Mode encodings
  localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
  localparam logic [MODE_W-1:0] MODE_OFF = 3'h7;

  // Sticky event bits
  localparam int unsigned EVT_W = 2;
  localparam int unsigned EVT_CHANGE = 0;
  localparam int unsigned EVT_SOFT = 1;

  // Reset values
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;
  localparam logic [NUM_CMP-1:0] OUT_RESET = 2'h0;

  // AHB-Lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } bus_state_t;

endpackage

// [shared/irq_evt_if.sv]
// Carrier between the register top and the sticky interrupt unit
`timescale 1ns/100ps
interface irq_evt_if;
  import cmp_pkg::*;
  logic [EVT_W-1:0] set;
  logic wr_status;
  logic wr_mask;
  logic [EVT_W-1:0] wdata;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;
  logic irq;

  modport owner (
    output set, wr_status, wr_mask, wdata,
    input status, mask, irq
  );
  modport unit (
    input set, wr_status, wr_mask, wdata,
    output status, mask, irq
  );
endinterface

// [verif/cmp_change_irq_checker.sv]
// Port-level assertions for the comparator change interrupt block
`timescale 1ns/100ps
module cmp_change_irq_checker
  import cmp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Bus
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [DATA_W-1:0] hwdata_in,
  input wire logic [DATA_W-1:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // Block pins
  input wire logic sleep_in,
  input wire logic cmp_power_down_out,
  input wire logic [MODE_W-1:0] cmp_mode_out,
  input wire logic wake_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic rd_take;
  logic wr_take;
  logic ctl_wr;
  assign rd_take = hsel_in && htrans_in[1] && !hwrite_in && hreadyout_out;
  assign wr_take = hsel_in && htrans_in[1] && hwrite_in && hreadyout_out;
  assign ctl_wr = wr_take && haddr_in == 32'h0000_0000
    && hsize_in == HSIZE_WORD;

  property p_read_wait;
    rd_take |=> !hreadyout_out ##1 hreadyout_out;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait is not one cycle");
  property p_write_fast;
    wr_take |=> hreadyout_out;
  endproperty
  a_write_fast: assert property (p_write_fast)
    else $error("write data phase stalled");
  property p_okay;
    hresp_out == HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay)
    else $error("response is not okay");
  property p_rdata_hold;
    $changed(hrdata_out) |-> !$past(hreadyout_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved outside a read");
  property p_mode_write;
    ctl_wr ##1 hreadyout_out |=> cmp_mode_out == $past(hwdata_in[2:0]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode field did not take written value");
  property p_mode_kept;
    $changed(cmp_mode_out) |-> $past(ctl_wr, 2);
  endproperty
  a_mode_kept: assert property (p_mode_kept)
    else $error("mode field changed without a write");
  property p_off_down;
    cmp_mode_out == MODE_OFF && $stable(cmp_mode_out) |-> cmp_power_down_out;
  endproperty
  a_off_down: assert property (p_off_down)
    else $error("off mode left comparators powered");
  property p_rst_down;
    cmp_mode_out == MODE_RESET && $stable(cmp_mode_out)
      |-> cmp_power_down_out;
  endproperty
  a_rst_down: assert property (p_rst_down)
    else $error("reset mode left comparators powered");
  property p_active_up;
    cmp_mode_out != MODE_OFF && cmp_mode_out != MODE_RESET
      && $stable(cmp_mode_out) |-> !cmp_power_down_out;
  endproperty
  a_active_up: assert property (p_active_up)
    else $error("active mode kept comparators down");
  property p_wake_sleep;
    !$past(sleep_in) |-> !wake_out;
  endproperty
  a_wake_sleep: assert property (p_wake_sleep)
    else $error("wake raised while awake");
endmodule

// [verif/comparator_change_interrupt_bench.sv]
// Self-checking bench for the comparator change interrupt block
`timescale 1ns/100ps
module comparator_change_interrupt_bench;
  import cmp_pkg::*;
  logic ref_clk_in = 0, arst_n_in = 0, hsel = 0, hwrite = 0, sleep = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_q;
  logic [1:0] htrans = 0, raw = 0;
  logic [2:0] hsize = HSIZE_WORD, mode;
  logic rdy, rdy_q, hresp, pd, cirq, wake, irq;
  logic [15:0] rnd = 16'h0013;
  int errors = 0, check_count = 0;
  int m_live = 0, m_ref = 0, m_mode = 0, m_flag = 0, m_stat = 0;
  int m_mask = 0, m_ce = 0, m_en = 0;

  cmp_change_irq dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(rdy), .hresp_out(hresp),
    .cmp_one_raw_in(raw[0]), .cmp_two_raw_in(raw[1]), .sleep_in(sleep),
    .cmp_power_down_out(pd), .cmp_mode_out(mode), .cmp_irq_out(cirq),
    .wake_out(wake), .irq_out(irq));

  always #5 ref_clk_in = ~ref_clk_in;
  // Sampled mid-cycle so the rising edge sees what the slave presents
  always @(negedge ref_clk_in) begin
    rdy_q = rdy;
    rd_q = hrdata;
  end

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int exp_reg(input logic [7:0] a);
    case (a)
      8'h00: return (m_live << 6) | m_mode;
      8'h04: return m_flag << 6;
      8'h08: return m_ce << 6;
      8'h0C: return m_en;
      8'h10: return m_stat;
      8'h14: return m_mask;
      default: return 0;
    endcase
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (rdy_q !== 1'b1 && n < 64);
    if (rdy_q !== 1'b1) begin
      errors++;
      give_verdict;
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask
  task mis;
    if (m_live != m_ref) begin
      m_flag = 1;
      m_stat |= 1;
    end
  endtask
  task mread(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000);
    if (a == OFS_CMP_CONTROL)
      m_ref = m_live;
    chk(rd_q, exp_reg(a));
  endtask
  task mwrite(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    case (a)
      8'h00: begin
        m_mode = d[2:0];
        m_ref = m_live;
      end
      8'h04: begin
        m_flag = d[6];
        m_stat |= d[6] << 1;
      end
      8'h08: m_ce = d[6];
      8'h0C: m_en = d & 32'h0000_00C0;
      8'h10: m_stat &= ~d[1:0];
      8'h14: m_mask = d[1:0];
      default: ;
    endcase
    mis;
  endtask
  task drive(input logic [1:0] v);
    @(posedge ref_clk_in);
    raw <= v;
    repeat (6) @(posedge ref_clk_in);
    if (m_mode != 0 && m_mode != 7)
      m_live = v;
    mis;
  endtask
  task pins;
    logic [6:0] e;
    repeat (2) @(posedge ref_clk_in);
    #1;
    e = {m_flag && m_ce && m_en == 192, sleep && m_flag && m_ce,
      (m_stat & m_mask) != 0, m_mode == 0 || m_mode == 7, m_mode[2:0]};
    chk({cirq, wake, irq, pd, mode}, e);
  endtask

  initial begin
    repeat (16) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    pins;
    for (int a = 0; a < 28; a += 4)
      mread(a[7:0]);
    mwrite(8'h18, 32'hFFFF_FFFF);
    mread(8'h18);
    $display("test reset values done");
    mwrite(8'h00, 32'(1 + rnd % 6));
    pins;
    for (int i = 0; i < 6; i++) begin
      rnd = nxt(rnd);
      drive(rnd[1:0]);
      mread(8'h04);
      mread(8'h00);
      mwrite(8'h04, {rnd, 16'h0000});
      mread(8'h04);
    end
    $display("test change flag done");
    drive(~raw);
    mwrite(8'h04, 32'h0000_0000);
    mread(8'h04);
    mread(8'h00);
    mwrite(8'h04, 32'h0000_0000);
    mread(8'h04);
    $display("test mismatch done");
    mwrite(8'h04, 32'h0000_0040);
    mread(8'h04);
    for (int i = 0; i < 8; i++) begin
      mwrite(8'h08, 32'(i & 1) << 6);
      mwrite(8'h0C, 32'(i >> 1) << 6);
      pins;
    end
    mwrite(8'h14, 32'h0000_0003);
    pins;
    mwrite(8'h10, 32'h0000_0003);
    pins;
    mwrite(8'h14, 32'h0000_0000);
    mwrite(8'h04, 32'h0000_0040);
    pins;
    mread(8'h10);
    $display("test enables done");
    mwrite(8'h04, 32'h0000_0000);
    @(posedge ref_clk_in);
    sleep <= 1'b1;
    drive(~raw);
    pins;
    mread(8'h00);
    @(posedge ref_clk_in);
    sleep <= 1'b0;
    $display("test sleep done");
    mwrite(8'h00, 32'h0000_0007);
    mwrite(8'h04, 32'h0000_0000);
    drive(~raw);
    pins;
    mread(8'h04);
    @(posedge ref_clk_in);
    arst_n_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    chk({pd, mode}, 4'h8);
    $display("test off and reset done");
    give_verdict;
  end
endmodule

bind cmp_change_irq cmp_change_irq_checker chk_i (
  .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .sleep_in(sleep_in), .cmp_power_down_out(cmp_power_down_out),
  .cmp_mode_out(cmp_mode_out), .wake_out(wake_out));
